// ### rtl/dmad_consts.svh
// Constants for the data memory address decoder
`ifndef DMAD_CONSTS_SVH
`define DMAD_CONSTS_SVH
`define DMAD_IDATA_HALF 8'h80
`define DMAD_BANK_END 8'h20
`define DMAD_BIT_END 8'h30
`define DMAD_XRAM_MSB 11
`define DMAD_XRAM_LIMIT 17'h01000
`define DMAD_FLASH_RSV_LO 16'hFC00
`define DMAD_FLASH_RSV_HI 16'hFFFF
`define DMAD_SECTOR_MSB 8
`define DMAD_SCRATCH_MSB 6
`define DMAD_PAGE_RST 8'h00
`endif

// ### rtl/dmad_pkg.sv
// Types for the data memory address decoder
package dmad_pkg;
  typedef enum logic [1:0] {
    DMAD_MAP_ONCHIP = 2'b00,
    DMAD_MAP_OFFCHIP = 2'b01,
    DMAD_MAP_SPLIT = 2'b10,
    DMAD_MAP_RSVD = 2'b11
  } dmad_map_t;
  typedef enum logic [1:0] {
    DMAD_TGT_RAM = 2'b00,
    DMAD_TGT_SPECIAL = 2'b01
  } dmad_itgt_t;
  typedef struct packed {
    logic valid;
    logic indirect;
    logic [7:0] addr;
  } dmad_iacc_t;
  typedef struct packed {
    logic sel_ram;
    logic sel_special;
    logic [7:0] ram_addr;
    logic [7:0] special_addr;
    logic [7:0] special_page;
    logic [1:0] bank;
    logic bit_area;
    logic upper_ram;
  } dmad_iroute_t;
  typedef struct packed {
    logic sel_onchip;
    logic sel_port;
    logic [11:0] onchip_addr;
    logic [15:0] port_addr;
  } dmad_xroute_t;
endpackage : dmad_pkg

// ### rtl/dmad_flash_guard.sv
// Program flash region checker: reserved area, sector and scratchpad indices
`timescale 1ns/100ps
`include "dmad_consts.svh"
module dmad_flash_guard #(
  parameter bit HAS_RSV = 1'b1
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] addr_i,
  input wire logic scratch_i,
  input wire logic wr_i,
  output logic allow_o,
  output logic [6:0] sector_o,
  output logic [6:0] scratch_off_o
);
  logic rsv;

  // Top 1 kB is held back from code on large parts
  assign rsv = HAS_RSV && !scratch_i && (addr_i >= `DMAD_FLASH_RSV_LO);

  // Registered so outputs settle one cycle after the request
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      allow_o <= 1'b0;
      sector_o <= 7'h00;
      scratch_off_o <= 7'h00;
    end else begin
      allow_o <= wr_i && !rsv;
      sector_o <= addr_i[15:`DMAD_SECTOR_MSB + 1];
      scratch_off_o <= addr_i[`DMAD_SCRATCH_MSB:0];
    end
  end

  a_rsv_blocked: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (HAS_RSV && wr_i && !scratch_i && addr_i >= 16'hFC00) |=> !allow_o)
    else $error("write into reserved flash allowed");
endmodule : dmad_flash_guard

// ### rtl/dmad_decoder.sv
// Data memory address decoder: internal, special register and external data spaces
`timescale 1ns/100ps
`include "dmad_consts.svh"
module dmad_decoder #(
  parameter bit HAS_RSV = 1'b1
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input dmad_pkg::dmad_iacc_t iacc_i,
  input wire logic [7:0] page_i,
  input wire logic page_we_i,
  input wire logic [1:0] bank_sel_i,
  input wire logic bit_acc_i,
  input wire logic [2:0] bit_num_i,
  input wire logic xacc_i,
  input wire logic [15:0] xaddr_i,
  input wire logic [7:0] xwdata_i,
  input wire logic xwr_i,
  input dmad_pkg::dmad_map_t map_i,
  input wire logic mux_mode_i,
  input wire logic [15:0] faddr_i,
  input wire logic fscratch_i,
  input wire logic fwr_i,
  output dmad_pkg::dmad_iroute_t iroute_o,
  output logic [7:0] bit_mask_o,
  output dmad_pkg::dmad_xroute_t xroute_o,
  output logic [15:0] port_ad_o,
  output logic [7:0] port_a_hi_o,
  output logic [7:0] port_d_o,
  output logic port_d_oe_n_o,
  output logic port_ale_o,
  output logic flash_allow_o,
  output logic [6:0] flash_sector_o,
  output logic [6:0] scratch_off_o
);
  import dmad_pkg::*;

  logic [7:0] page_q;
  logic upper;
  logic [7:0] eff_addr;
  logic x_onchip;
  logic [15:0] x_addr_q;
  logic [7:0] x_data_q;
  logic x_wr_q;
  typedef enum logic [1:0] {
    DMAD_PS_IDLE = 2'b00,
    DMAD_PS_ADDR = 2'b01,
    DMAD_PS_DATA = 2'b10
  } dmad_pst_t;
  dmad_pst_t pst_q;

  // ----------------------------------------------------------------
  // Special register page
  // ----------------------------------------------------------------
  // Page held so one direct address reaches many peripherals
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      page_q <= `DMAD_PAGE_RST;
    end else if (page_we_i) begin
      page_q <= page_i;
    end
  end

  // ----------------------------------------------------------------
  // Internal data space
  // ----------------------------------------------------------------
  assign upper = iacc_i.addr >= `DMAD_IDATA_HALF;
  // Bank bytes are relative to the selected bank when addr < 8
  assign eff_addr = (iacc_i.addr < 8'h08) ? {3'b000, bank_sel_i, iacc_i.addr[2:0]} : iacc_i.addr;

  // Route registered; special registers win only for direct upper accesses
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      iroute_o <= '0;
      bit_mask_o <= 8'h00;
    end else begin
      iroute_o.sel_special <= iacc_i.valid && upper && !iacc_i.indirect;
      iroute_o.sel_ram <= iacc_i.valid && (!upper || iacc_i.indirect);
      iroute_o.upper_ram <= iacc_i.valid && upper && iacc_i.indirect;
      iroute_o.ram_addr <= eff_addr;
      iroute_o.special_addr <= iacc_i.addr;
      iroute_o.special_page <= page_q;
      iroute_o.bank <= bank_sel_i;
      iroute_o.bit_area <= iacc_i.valid && bit_acc_i && (iacc_i.addr >= `DMAD_BANK_END)
        && (iacc_i.addr < `DMAD_BIT_END);
      bit_mask_o <= bit_acc_i ? (8'h01 << bit_num_i) : 8'hFF;
    end
  end

  // ----------------------------------------------------------------
  // External data space
  // ----------------------------------------------------------------
  // Split limit at 4 k; reserved map code falls back to on-chip only
  always_comb begin
    unique case (map_i)
      DMAD_MAP_OFFCHIP: x_onchip = 1'b0;
      DMAD_MAP_SPLIT: x_onchip = ({1'b0, xaddr_i} < `DMAD_XRAM_LIMIT);
      default: x_onchip = 1'b1;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      xroute_o <= '0;
    end else begin
      xroute_o.sel_onchip <= xacc_i && x_onchip;
      xroute_o.sel_port <= xacc_i && !x_onchip;
      // Upper four bits dropped so the block mirrors every 4 k
      xroute_o.onchip_addr <= xaddr_i[`DMAD_XRAM_MSB:0];
      xroute_o.port_addr <= xaddr_i;
    end
  end

  // ----------------------------------------------------------------
  // External memory port sequencer
  // ----------------------------------------------------------------
  // Multiplexed mode spends an address phase with a latch strobe
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pst_q <= DMAD_PS_IDLE;
      x_addr_q <= 16'h0000;
      x_data_q <= 8'h00;
      x_wr_q <= 1'b0;
    end else begin
      unique case (pst_q)
        DMAD_PS_IDLE: begin
          if (xacc_i && !x_onchip) begin
            x_addr_q <= xaddr_i;
            x_data_q <= xwdata_i;
            x_wr_q <= xwr_i;
            pst_q <= mux_mode_i ? DMAD_PS_ADDR : DMAD_PS_DATA;
          end
        end
        DMAD_PS_ADDR: pst_q <= DMAD_PS_DATA;
        DMAD_PS_DATA: pst_q <= DMAD_PS_IDLE;
        default: pst_q <= DMAD_PS_IDLE;
      endcase
    end
  end

  // Pins follow the phase; low byte shares data lines only when multiplexed
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      port_ad_o <= 16'h0000;
      port_a_hi_o <= 8'h00;
      port_d_o <= 8'h00;
      port_d_oe_n_o <= 1'b1;
      port_ale_o <= 1'b0;
    end else begin
      port_a_hi_o <= x_addr_q[15:8];
      port_ale_o <= (pst_q == DMAD_PS_ADDR);
      if (mux_mode_i) begin
        port_ad_o <= (pst_q == DMAD_PS_ADDR) ? x_addr_q : {x_addr_q[15:8], x_data_q};
      end else begin
        port_ad_o <= x_addr_q;
      end
      port_d_o <= x_data_q;
      port_d_oe_n_o <= !((pst_q == DMAD_PS_DATA) && x_wr_q);
    end
  end

  dmad_flash_guard #(
    .HAS_RSV(HAS_RSV)
  ) u_flash (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .addr_i(faddr_i),
    .scratch_i(fscratch_i),
    .wr_i(fwr_i),
    .allow_o(flash_allow_o),
    .sector_o(flash_sector_o),
    .scratch_off_o(scratch_off_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ind_upper_ram: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (iacc_i.valid && iacc_i.indirect && iacc_i.addr[7]) |=> (iroute_o.sel_ram && !iroute_o.sel_special))
    else $error("indirect upper access not sent to RAM");
  a_dir_special: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (iacc_i.valid && !iacc_i.indirect && iacc_i.addr[7]) |=> (iroute_o.sel_special && !iroute_o.sel_ram))
    else $error("direct upper access not sent to special registers");
  a_page_held: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (page_we_i ##1 !page_we_i) |=> (iroute_o.special_page == $past(page_i, 2)))
    else $error("special register page not applied");
  a_lower_ram: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (iacc_i.valid && !iacc_i.addr[7]) |=> iroute_o.sel_ram)
    else $error("lower RAM not reached");
  a_bank_addr: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (iacc_i.addr < 8'h08) |=> (iroute_o.ram_addr[7:3] == {3'b000, $past(bank_sel_i)}))
    else $error("bank register address wrong");
  a_bit_area: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (iacc_i.valid && bit_acc_i && iacc_i.addr >= 8'h20 && iacc_i.addr < 8'h30) |=> iroute_o.bit_area)
    else $error("bit area access not flagged");
  a_mirror_4k: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    xacc_i |=> (xroute_o.onchip_addr == $past(xaddr_i[11:0])))
    else $error("on-chip block not mirrored");
  a_split_map: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (xacc_i && map_i == DMAD_MAP_SPLIT) |=> (xroute_o.sel_port == ($past(xaddr_i) >= 16'h1000)))
    else $error("split mapping wrong");
  a_mux_ale: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (pst_q == DMAD_PS_IDLE && xacc_i && !x_onchip && mux_mode_i) |=> ##1 port_ale_o)
    else $error("address latch strobe missing");
endmodule : dmad_decoder

// ### testbench/dmad_port_model.sv
// Behavioural memory on the far side of the external memory port
`timescale 1ns/100ps
module dmad_port_model (
  input wire logic mclk_i,
  input wire logic mux_i,
  input wire logic ale_i,
  input wire logic [15:0] ad_i,
  input wire logic [7:0] d_i,
  input wire logic oe_n_i,
  output logic [15:0] addr_o,
  output logic [7:0] data_o
);
  // ----------------------------------------
  // Capture of address and write data
  // ----------------------------------------
  // Address comes with the latch strobe when shared, with the data phase when separate
  always_ff @(posedge mclk_i) begin
    if (ale_i || (!mux_i && !oe_n_i)) begin
      addr_o <= ad_i;
    end
    if (!oe_n_i) begin
      data_o <= mux_i ? ad_i[7:0] : d_i;
    end
  end
endmodule : dmad_port_model

// ### testbench/tb.sv
// Self-checking testbench for the data memory address decoder
`timescale 1ns/100ps
module tb;
  import dmad_pkg::*;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, page_we_i = 1'b0, bit_acc_i = 1'b0;
  logic xacc_i = 1'b0, xwr_i = 1'b0, mux_mode_i = 1'b0, fscratch_i = 1'b0, fwr_i = 1'b0;
  logic [7:0] page_i = 8'h00, xwdata_i = 8'h00;
  logic [1:0] bank_sel_i = 2'h0;
  logic [2:0] bit_num_i = 3'h0;
  logic [15:0] xaddr_i = 16'h0000, faddr_i = 16'h0000;
  dmad_iacc_t iacc_i = '0;
  dmad_map_t map_i = DMAD_MAP_ONCHIP;
  dmad_iroute_t iroute_o;
  dmad_xroute_t xroute_o;
  logic [15:0] port_ad_o, m_addr;
  logic [7:0] bit_mask_o, port_a_hi_o, port_d_o, m_data;
  logic port_d_oe_n_o, port_ale_o, flash_allow_o;
  logic [6:0] flash_sector_o, scratch_off_o;
  int errors = 0, tests_run = 0, cycles = 0;
  dmad_decoder #(.HAS_RSV(1'b1)) DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .iacc_i(iacc_i), .page_i(page_i), .page_we_i(page_we_i), .bank_sel_i(bank_sel_i),
    .bit_acc_i(bit_acc_i), .bit_num_i(bit_num_i), .xacc_i(xacc_i), .xaddr_i(xaddr_i),
    .xwdata_i(xwdata_i), .xwr_i(xwr_i), .map_i(map_i), .mux_mode_i(mux_mode_i),
    .faddr_i(faddr_i), .fscratch_i(fscratch_i), .fwr_i(fwr_i), .iroute_o(iroute_o),
    .bit_mask_o(bit_mask_o), .xroute_o(xroute_o), .port_ad_o(port_ad_o),
    .port_a_hi_o(port_a_hi_o), .port_d_o(port_d_o), .port_d_oe_n_o(port_d_oe_n_o),
    .port_ale_o(port_ale_o), .flash_allow_o(flash_allow_o),
    .flash_sector_o(flash_sector_o), .scratch_off_o(scratch_off_o));
  dmad_port_model mem (.mclk_i(mclk_i), .mux_i(mux_mode_i), .ale_i(port_ale_o),
    .ad_i(port_ad_o), .d_i(port_d_o), .oe_n_i(port_d_oe_n_o), .addr_o(m_addr),
    .data_o(m_data));
  // ----------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------
  always #4 mclk_i = ~mclk_i;
  // Whole run is under a hundred cycles, so a hang is cut well before it costs time
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Inputs change at the falling edge; the registered answer is read one cycle on
  task automatic iacc(input logic ind, input logic [7:0] a, input logic [1:0] bk,
      input logic ba, input logic [2:0] bn);
    iacc_i = '{valid: 1'b1, indirect: ind, addr: a};
    bank_sel_i = bk;
    bit_acc_i = ba;
    bit_num_i = bn;
    @(negedge mclk_i);
  endtask : iacc
  task automatic test_internal();
    iacc(1'b1, 8'h90, 2'h0, 1'b0, 3'h0);
    chk({iroute_o.sel_ram, iroute_o.upper_ram, iroute_o.sel_special}, 16'h6);
    chk(iroute_o.ram_addr, 16'h90);
    iacc(1'b0, 8'h90, 2'h0, 1'b0, 3'h0);
    chk({iroute_o.sel_ram, iroute_o.sel_special, iroute_o.special_addr}, 16'h190);
    for (int m = 0; m < 2; m++) begin
      iacc(m[0], 8'h7F, 2'h0, 1'b0, 3'h0);
      chk({iroute_o.sel_ram, iroute_o.sel_special, iroute_o.ram_addr}, 16'h27F);
    end
    for (int b = 0; b < 4; b++) begin
      iacc(1'b0, 8'h05, b[1:0], 1'b0, 3'h0);
      chk({iroute_o.bank, iroute_o.ram_addr}, {b[1:0], 3'h0, b[1:0], 3'h5});
    end
    iacc(1'b0, 8'h2F, 2'h0, 1'b1, 3'h3);
    chk({iroute_o.bit_area, bit_mask_o}, 16'h108);
    iacc(1'b0, 8'h2F, 2'h0, 1'b0, 3'h0);
    chk(bit_mask_o, 16'hFF);
    // Bit accesses just outside the bit area must not be flagged
    iacc(1'b0, 8'h30, 2'h0, 1'b1, 3'h7);
    chk({iroute_o.bit_area, bit_mask_o}, 16'h080);
    iacc(1'b0, 8'h1F, 2'h0, 1'b1, 3'h0);
    chk({iroute_o.bit_area, bit_mask_o}, 16'h001);
    page_i = 8'hA5;
    page_we_i = 1'b1;
    @(negedge mclk_i);
    page_we_i = 1'b0;
    iacc(1'b0, 8'hC0, 2'h0, 1'b0, 3'h0);
    chk({iroute_o.special_page, iroute_o.special_addr}, 16'hA5C0);
    iacc_i = '0;
    $display("internal space test done");
  endtask : test_internal
  // Map code, address and expected {on-chip, port} select for each external case
  task automatic test_xroute();
    dmad_map_t mp[5] = '{DMAD_MAP_ONCHIP, DMAD_MAP_OFFCHIP, DMAD_MAP_SPLIT,
                         DMAD_MAP_SPLIT, DMAD_MAP_RSVD};
    logic [15:0] ad[5] = '{16'h5123, 16'h5123, 16'h0FFF, 16'h1000, 16'hF123};
    logic [1:0] sel[5] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h2};
    for (int i = 0; i < 5; i++) begin
      map_i = mp[i];
      xaddr_i = ad[i];
      xacc_i = 1'b1;
      @(negedge mclk_i);
      xacc_i = 1'b0;
      chk({xroute_o.sel_onchip, xroute_o.sel_port}, sel[i]);
      if (sel[i][1]) chk(xroute_o.onchip_addr, ad[i][11:0]);
      else chk(xroute_o.port_addr, ad[i]);
      repeat (4) @(negedge mclk_i);
    end
    $display("external mapping test done");
  endtask : test_xroute
  task automatic test_port(input logic mx, input logic [15:0] a, input logic [7:0] d);
    mux_mode_i = mx;
    map_i = DMAD_MAP_OFFCHIP;
    xaddr_i = a;
    xwdata_i = d;
    xwr_i = 1'b1;
    xacc_i = 1'b1;
    @(negedge mclk_i);
    xacc_i = 1'b0;
    for (int n = 0; n < 6 && (mx ? port_ale_o !== 1'b1 : port_d_oe_n_o !== 1'b0); n++)
      @(negedge mclk_i);
    chk(port_ad_o, a);
    chk({port_a_hi_o, 7'h0, port_ale_o}, {a[15:8], 7'h0, mx});
    if (mx) begin
      @(negedge mclk_i);
      chk(port_ad_o, {a[15:8], d});
      chk(port_d_oe_n_o, 16'h0);
    end else begin
      chk({port_d_o, 7'h0, port_d_oe_n_o}, {d, 8'h0});
    end
    @(negedge mclk_i);
    chk(m_addr, a);
    chk(m_data, d);
    xwr_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    $display("port cycle test done");
  endtask : test_port
  task automatic flash(input logic [15:0] a, input logic s, input logic w, input logic ex);
    faddr_i = a;
    fscratch_i = s;
    fwr_i = w;
    @(negedge mclk_i);
    chk(flash_allow_o, ex);
    if (!s) chk(flash_sector_o, a[15:9]);
    else chk(scratch_off_o, a[6:0]);
  endtask : flash
  task automatic end_of_test();
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    @(negedge mclk_i);
    chk(port_d_oe_n_o, 16'h1);
    test_internal();
    test_xroute();
    test_port(1'b1, 16'h1234, 8'h5A);
    test_port(1'b0, 16'hBEEF, 8'hC3);
    flash(16'hFBFF, 1'b0, 1'b1, 1'b1);
    flash(16'hFC00, 1'b0, 1'b1, 1'b0);
    flash(16'hFFFF, 1'b0, 1'b1, 1'b0);
    flash(16'h0245, 1'b0, 1'b0, 1'b0);
    flash(16'hFC45, 1'b1, 1'b1, 1'b1);
    $display("flash test done");
    end_of_test();
  end
endmodule : tb
